// file: hw/ipc_pkg.sv
// Constants, types and helpers shared by both link ends
package ipc_pkg;
  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int NCHAN = 4;
  localparam int CHW = 2;
  localparam int ADDR_W = 6;
  localparam int IRQ_W = 9;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [5:0] OFF_CMD0 = 6'h00;
  localparam logic [5:0] OFF_DATA0 = 6'h10;
  localparam logic [5:0] OFF_STAT = 6'h20;
  localparam logic [5:0] OFF_ERR = 6'h24;
  localparam logic [5:0] OFF_IRQ_MASK = 6'h28;
  localparam logic [5:0] OFF_IRQ_STAT = 6'h2C;
  localparam logic [5:0] OFF_RX_DATA = 6'h30;
  localparam logic [5:0] OFF_RX_INFO = 6'h34;
  localparam logic [5:0] BANK_MASK = 6'h30;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CMD_WRITE_BIT = 0;
  localparam int CMD_STREAM_BIT = 1;
  localparam int STAT_ACKD_LSB = 0;
  localparam int STAT_OUT_LSB = 4;
  localparam int STAT_TOKEN_BIT = 8;
  localparam int STAT_PEND_LSB = 12;
  localparam int IRQ_ACK_LSB = 0;
  localparam int IRQ_TO_LSB = 4;
  localparam int IRQ_RX_BIT = 8;
  localparam int RXI_STREAM_BIT = 4;
  // ----------------------------------------
  // Reset values and bus answers
  // ----------------------------------------
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 9'h000;
  localparam logic [31:0] DATA_RST = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ = 20;
  localparam int ACK_TIMEOUT_NS = 10000;
  localparam int ACK_TIMEOUT_CYC = ACK_TIMEOUT_NS * CLK_MHZ / 1000;
  localparam int TMR_W = 8;
  localparam logic [TMR_W-1:0] TMR_LOAD = TMR_W'(ACK_TIMEOUT_CYC - 1);
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {TOK_AWAY, TOK_HELD, TOK_WAIT} tok_state_t;

  // Lowest set channel of a request vector
  function automatic logic [CHW-1:0] first_set(input logic [NCHAN-1:0] v);
    logic [CHW-1:0] r;
    r = '0;
    for (int i = NCHAN - 1; i >= 0; i--)
    begin
      if (v[i])
        r = CHW'(i);
    end
    return r;
  endfunction
endpackage

// file: hw/ipc_link_if.sv
// Link between the initiator end and the peer end
`timescale 1ns/1ps
interface ipc_link_if;
  // Initiator to peer
  logic i2t_frame;
  logic [1:0] i2t_chan;
  logic i2t_stream;
  logic [31:0] i2t_data;
  logic i2t_trig;
  logic i2t_ack;
  logic [1:0] i2t_ack_chan;
  // Peer to initiator
  logic t2i_frame;
  logic [1:0] t2i_chan;
  logic t2i_stream;
  logic [31:0] t2i_data;
  logic t2i_trig;
  logic t2i_ack;
  logic [1:0] t2i_ack_chan;

  modport dev (
    output i2t_frame, i2t_chan, i2t_stream, i2t_data, i2t_trig, i2t_ack, i2t_ack_chan,
    input t2i_frame, t2i_chan, t2i_stream, t2i_data, t2i_trig, t2i_ack, t2i_ack_chan
  );
  modport peer (
    input i2t_frame, i2t_chan, i2t_stream, i2t_data, i2t_trig, i2t_ack, i2t_ack_chan,
    output t2i_frame, t2i_chan, t2i_stream, t2i_data, t2i_trig, t2i_ack, t2i_ack_chan
  );
endinterface

// file: hw/ipc_dev_end.sv
// Initiator end: register file, channel tracking and token passing
`timescale 1ns/1ps
module ipc_dev_end (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Link
  ipc_link_if.dev link,
  // AXI4-Lite slave
  input wire logic [5:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [5:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Interrupt
  output logic irq
);
  localparam int N = ipc_pkg::NCHAN;
  localparam int CW = ipc_pkg::CHW;

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q, irq_q;
  logic aw_have_q, w_have_q;
  logic [5:0] aw_addr_q;
  logic [31:0] w_data_q, rdata_q;
  logic [3:0] w_strb_q;
  logic [1:0] bresp_q, rresp_q;
  logic [N-1:0] pend_q, pend_strm_q, out_q, ackd_q, tof_q;
  logic [31:0] data_q [N];
  logic [ipc_pkg::IRQ_W-1:0] mask_q, istat_q;
  logic [31:0] rx_data_q;
  logic [CW-1:0] rx_chan_q, cur_q, lnk_chan_q, ack_chan_q;
  logic rx_strm_q, lnk_frame_q, lnk_strm_q, lnk_trig_q, ack_q;
  logic [31:0] lnk_data_q;
  logic [ipc_pkg::TMR_W-1:0] tmr_q;
  ipc_pkg::tok_state_t tok_q;

  // ----------------------------------------
  // Register decode
  // ----------------------------------------
  function automatic logic reg_mapped(input logic [5:0] a);
    return ((a & ipc_pkg::BANK_MASK) == ipc_pkg::OFF_CMD0) ||
           ((a & ipc_pkg::BANK_MASK) == ipc_pkg::OFF_DATA0) ||
           (a == ipc_pkg::OFF_STAT) || (a == ipc_pkg::OFF_ERR) ||
           (a == ipc_pkg::OFF_IRQ_MASK) || (a == ipc_pkg::OFF_IRQ_STAT) ||
           (a == ipc_pkg::OFF_RX_DATA) || (a == ipc_pkg::OFF_RX_INFO);
  endfunction

  function automatic logic [31:0] reg_read(input logic [5:0] a);
    logic [31:0] r;
    logic [CW-1:0] c;
    r = '0;
    c = a[3:2];
    if ((a & ipc_pkg::BANK_MASK) == ipc_pkg::OFF_CMD0)
    begin
      r[ipc_pkg::CMD_WRITE_BIT] = pend_q[c] & ~pend_strm_q[c];
      r[ipc_pkg::CMD_STREAM_BIT] = pend_q[c] & pend_strm_q[c];
    end
    else if ((a & ipc_pkg::BANK_MASK) == ipc_pkg::OFF_DATA0)
      r = data_q[c];
    else if (a == ipc_pkg::OFF_STAT)
    begin
      r[ipc_pkg::STAT_ACKD_LSB +: N] = ackd_q;
      r[ipc_pkg::STAT_OUT_LSB +: N] = out_q;
      r[ipc_pkg::STAT_TOKEN_BIT] = (tok_q != ipc_pkg::TOK_AWAY);
      r[ipc_pkg::STAT_PEND_LSB +: N] = pend_q;
    end
    else if (a == ipc_pkg::OFF_ERR)
      r[N-1:0] = tof_q;
    else if (a == ipc_pkg::OFF_IRQ_MASK)
      r[ipc_pkg::IRQ_W-1:0] = mask_q;
    else if (a == ipc_pkg::OFF_IRQ_STAT)
      r[ipc_pkg::IRQ_W-1:0] = istat_q;
    else if (a == ipc_pkg::OFF_RX_DATA)
      r = rx_data_q;
    else if (a == ipc_pkg::OFF_RX_INFO)
    begin
      r[CW-1:0] = rx_chan_q;
      r[ipc_pkg::RXI_STREAM_BIT] = rx_strm_q;
    end
    return r;
  endfunction

  // ----------------------------------------
  // Write decode and events
  // ----------------------------------------
  logic wr_fire, cmd_hit, data_hit, launch, ack_ev, to_ev;
  logic [31:0] bm, ones, wval;
  logic [CW-1:0] wch, lch;
  logic [N-1:0] sw_go, sw_bad, sw_ok, ack_vec, to_vec, tof_clr;
  logic [ipc_pkg::IRQ_W-1:0] ist_set, ist_clr;

  always_comb
  begin
    wr_fire = aw_have_q & w_have_q & ~bvalid_q;
    bm = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
    ones = w_data_q & bm;
    wval = (reg_read(aw_addr_q) & ~bm) | ones;
    wch = aw_addr_q[3:2];
    cmd_hit = wr_fire & ((aw_addr_q & ipc_pkg::BANK_MASK) == ipc_pkg::OFF_CMD0);
    data_hit = wr_fire & ((aw_addr_q & ipc_pkg::BANK_MASK) == ipc_pkg::OFF_DATA0);
    sw_go = '0;
    if (cmd_hit & (ones[ipc_pkg::CMD_WRITE_BIT] | ones[ipc_pkg::CMD_STREAM_BIT]))
      sw_go[wch] = 1'b1;
    sw_bad = sw_go & (pend_q | out_q);
    sw_ok = sw_go & ~sw_bad;
    launch = (tok_q == ipc_pkg::TOK_HELD) & (|pend_q);
    lch = ipc_pkg::first_set(pend_q);
    ack_ev = (tok_q == ipc_pkg::TOK_WAIT) & link.t2i_ack & (link.t2i_ack_chan == cur_q);
    to_ev = (tok_q == ipc_pkg::TOK_WAIT) & ~ack_ev & (tmr_q == '0);
    ack_vec = '0;
    to_vec = '0;
    ack_vec[cur_q] = ack_ev;
    to_vec[cur_q] = to_ev;
    tof_clr = '0;
    ist_clr = '0;
    if (wr_fire & (aw_addr_q == ipc_pkg::OFF_ERR))
      tof_clr = ones[N-1:0];
    if (wr_fire & (aw_addr_q == ipc_pkg::OFF_IRQ_STAT))
      ist_clr = ones[ipc_pkg::IRQ_W-1:0];
    ist_set = '0;
    ist_set[ipc_pkg::IRQ_ACK_LSB +: N] = ack_vec;
    ist_set[ipc_pkg::IRQ_TO_LSB +: N] = to_vec | sw_bad;
    ist_set[ipc_pkg::IRQ_RX_BIT] = link.t2i_frame;
  end

  // ----------------------------------------
  // AXI4-Lite write channels
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= ipc_pkg::RESP_OKAY;
    end
    else
    begin
      awready_q <= awvalid & ~awready_q & ~aw_have_q;
      wready_q <= wvalid & ~wready_q & ~w_have_q;
      if (awvalid & awready_q)
      begin
        aw_have_q <= 1'b1;
        aw_addr_q <= awaddr;
      end
      if (wvalid & wready_q)
      begin
        w_have_q <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      if (wr_fire)
      begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= reg_mapped(aw_addr_q) ? ipc_pkg::RESP_OKAY : ipc_pkg::RESP_SLVERR;
      end
      else if (bvalid_q & bready)
        bvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // AXI4-Lite read channels
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= ipc_pkg::RESP_OKAY;
    end
    else
    begin
      arready_q <= arvalid & ~arready_q & ~rvalid_q;
      if (arvalid & arready_q)
      begin
        rvalid_q <= 1'b1;
        rdata_q <= reg_read(araddr);
        rresp_q <= reg_mapped(araddr) ? ipc_pkg::RESP_OKAY : ipc_pkg::RESP_SLVERR;
      end
      else if (rvalid_q & rready)
        rvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Channel requests and tracking
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pend_q <= '0;
      pend_strm_q <= '0;
      out_q <= '0;
      ackd_q <= '0;
      for (int i = 0; i < N; i++)
        data_q[i] <= ipc_pkg::DATA_RST;
    end
    else
    begin
      for (int i = 0; i < N; i++)
      begin
        if (data_hit && (wch == CW'(i)))
          data_q[i] <= wval;
        if (launch && (lch == CW'(i)))
        begin
          pend_q[i] <= 1'b0;
          out_q[i] <= 1'b1;
        end
        if (sw_ok[i])
        begin
          pend_q[i] <= 1'b1;
          pend_strm_q[i] <= ones[ipc_pkg::CMD_STREAM_BIT];
          ackd_q[i] <= 1'b0;
        end
        if (ack_vec[i] | to_vec[i])
          out_q[i] <= 1'b0;
        if (ack_vec[i])
          ackd_q[i] <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Error, interrupt status and mask
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tof_q <= '0;
      istat_q <= '0;
      mask_q <= ipc_pkg::IRQ_MASK_RST;
      irq_q <= 1'b0;
    end
    else
    begin
      tof_q <= (tof_q & ~tof_clr) | to_vec | sw_bad;
      istat_q <= (istat_q & ~ist_clr) | ist_set;
      if (wr_fire & (aw_addr_q == ipc_pkg::OFF_IRQ_MASK))
        mask_q <= wval[ipc_pkg::IRQ_W-1:0];
      irq_q <= |(istat_q & mask_q);
    end
  end

  // ----------------------------------------
  // Token passing and frame launch
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tok_q <= ipc_pkg::TOK_HELD;
      cur_q <= '0;
      tmr_q <= '0;
      lnk_frame_q <= 1'b0;
      lnk_chan_q <= '0;
      lnk_strm_q <= 1'b0;
      lnk_data_q <= '0;
      lnk_trig_q <= 1'b0;
    end
    else
    begin
      lnk_frame_q <= 1'b0;
      lnk_trig_q <= 1'b0;
      unique case (tok_q)
        ipc_pkg::TOK_AWAY:
        begin
          if (link.t2i_trig)
            tok_q <= ipc_pkg::TOK_HELD;
        end
        ipc_pkg::TOK_HELD:
        begin
          if (launch)
          begin
            lnk_frame_q <= 1'b1;
            lnk_chan_q <= lch;
            lnk_strm_q <= pend_strm_q[lch];
            lnk_data_q <= data_q[lch];
            cur_q <= lch;
            tmr_q <= ipc_pkg::TMR_LOAD;
            tok_q <= ipc_pkg::TOK_WAIT;
          end
          else
          begin
            lnk_trig_q <= 1'b1;
            tok_q <= ipc_pkg::TOK_AWAY;
          end
        end
        ipc_pkg::TOK_WAIT:
        begin
          if (ack_ev | to_ev)
          begin
            lnk_trig_q <= 1'b1;
            tok_q <= ipc_pkg::TOK_AWAY;
          end
          else
            tmr_q <= tmr_q - 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Frames from the peer
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rx_data_q <= '0;
      rx_chan_q <= '0;
      rx_strm_q <= 1'b0;
      ack_q <= 1'b0;
      ack_chan_q <= '0;
    end
    else
    begin
      ack_q <= link.t2i_frame;
      if (link.t2i_frame)
      begin
        rx_data_q <= link.t2i_data;
        rx_chan_q <= link.t2i_chan;
        rx_strm_q <= link.t2i_stream;
        ack_chan_q <= link.t2i_chan;
      end
    end
  end

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign irq = irq_q;
  assign link.i2t_frame = lnk_frame_q;
  assign link.i2t_chan = lnk_chan_q;
  assign link.i2t_stream = lnk_strm_q;
  assign link.i2t_data = lnk_data_q;
  assign link.i2t_trig = lnk_trig_q;
  assign link.i2t_ack = ack_q;
  assign link.i2t_ack_chan = ack_chan_q;
endmodule

// file: hw/ipc_peer_end.sv
// Peer end: acknowledges frames and writes back only while holding the token
`timescale 1ns/1ps
module ipc_peer_end (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Link
  ipc_link_if.peer link,
  // Outgoing write request
  input wire logic tx_req,
  input wire logic [1:0] tx_chan,
  input wire logic tx_stream,
  input wire logic [31:0] tx_data,
  output logic tx_busy,
  output logic tx_done,
  output logic tx_timeout,
  // Received frames
  output logic rx_valid,
  output logic [1:0] rx_chan,
  output logic rx_stream,
  output logic [31:0] rx_data
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  ipc_pkg::tok_state_t tok_q;
  logic pend_q, busy_q, done_q, tout_q, frame_q, trig_q, ack_q, strm_q;
  logic rxv_q, rxs_q;
  logic [1:0] chan_q, ack_chan_q, rxc_q;
  logic [31:0] data_q, rxd_q;
  logic [ipc_pkg::TMR_W-1:0] tmr_q;
  logic ack_ev, to_ev;

  assign ack_ev = (tok_q == ipc_pkg::TOK_WAIT) & link.i2t_ack & (link.i2t_ack_chan == chan_q);
  assign to_ev = (tok_q == ipc_pkg::TOK_WAIT) & ~ack_ev & (tmr_q == '0);

  // ----------------------------------------
  // Token passing and outgoing writes
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tok_q <= ipc_pkg::TOK_AWAY;
      pend_q <= 1'b0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      tout_q <= 1'b0;
      frame_q <= 1'b0;
      trig_q <= 1'b0;
      chan_q <= '0;
      strm_q <= 1'b0;
      data_q <= '0;
      tmr_q <= '0;
    end
    else
    begin
      frame_q <= 1'b0;
      trig_q <= 1'b0;
      done_q <= 1'b0;
      tout_q <= 1'b0;
      if (tx_req & ~busy_q)
      begin
        pend_q <= 1'b1;
        busy_q <= 1'b1;
        chan_q <= tx_chan;
        strm_q <= tx_stream;
        data_q <= tx_data;
      end
      unique case (tok_q)
        ipc_pkg::TOK_AWAY:
        begin
          if (link.i2t_trig)
            tok_q <= ipc_pkg::TOK_HELD;
        end
        ipc_pkg::TOK_HELD:
        begin
          if (pend_q)
          begin
            frame_q <= 1'b1;
            pend_q <= 1'b0;
            tmr_q <= ipc_pkg::TMR_LOAD;
            tok_q <= ipc_pkg::TOK_WAIT;
          end
          else
          begin
            trig_q <= 1'b1;
            tok_q <= ipc_pkg::TOK_AWAY;
          end
        end
        ipc_pkg::TOK_WAIT:
        begin
          if (ack_ev | to_ev)
          begin
            trig_q <= 1'b1;
            busy_q <= 1'b0;
            done_q <= ack_ev;
            tout_q <= to_ev;
            tok_q <= ipc_pkg::TOK_AWAY;
          end
          else
            tmr_q <= tmr_q - 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Incoming frames and acknowledgement
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ack_q <= 1'b0;
      ack_chan_q <= '0;
      rxv_q <= 1'b0;
      rxc_q <= '0;
      rxs_q <= 1'b0;
      rxd_q <= '0;
    end
    else
    begin
      ack_q <= link.i2t_frame;
      rxv_q <= link.i2t_frame;
      if (link.i2t_frame)
      begin
        ack_chan_q <= link.i2t_chan;
        rxc_q <= link.i2t_chan;
        rxs_q <= link.i2t_stream;
        rxd_q <= link.i2t_data;
      end
    end
  end

  assign tx_busy = busy_q;
  assign tx_done = done_q;
  assign tx_timeout = tout_q;
  assign rx_valid = rxv_q;
  assign rx_chan = rxc_q;
  assign rx_stream = rxs_q;
  assign rx_data = rxd_q;
  assign link.t2i_frame = frame_q;
  assign link.t2i_chan = chan_q;
  assign link.t2i_stream = strm_q;
  assign link.t2i_data = data_q;
  assign link.t2i_trig = trig_q;
  assign link.t2i_ack = ack_q;
  assign link.t2i_ack_chan = ack_chan_q;
endmodule

// file: tb/ipc_link_chk.sv
// Link checker between the initiator end and the peer end
`timescale 1ns/1ps
module ipc_link_chk (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Initiator to peer
  input wire logic i2t_frame,
  input wire logic [1:0] i2t_chan,
  input wire logic i2t_trig,
  input wire logic i2t_ack,
  input wire logic [1:0] i2t_ack_chan,
  // Peer to initiator
  input wire logic t2i_frame,
  input wire logic [1:0] t2i_chan,
  input wire logic t2i_trig,
  input wire logic t2i_ack,
  input wire logic [1:0] t2i_ack_chan
);
  // ----------------------------------------
  // Token owner as seen on the wire
  // ----------------------------------------
  logic peer_tok_q;

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      peer_tok_q <= 1'b0;
    else if (i2t_trig)
      peer_tok_q <= 1'b1;
    else if (t2i_trig)
      peer_tok_q <= 1'b0;
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);

  sequence acked_s;
    !i2t_trig ##1 (t2i_ack && !i2t_trig);
  endsequence
  sequence handback_s;
    1'b1 ##1 i2t_trig;
  endsequence

  ack_dev_a: assert property (t2i_frame |=> i2t_ack && i2t_ack_chan == $past(t2i_chan))
    else $error("initiator ack late or wrong channel");
  ack_peer_a: assert property (i2t_frame |=> t2i_ack && t2i_ack_chan == $past(i2t_chan))
    else $error("peer ack late or wrong channel");
  no_overlap_a: assert property (!(i2t_frame && t2i_frame))
    else $error("both ends framing at once");
  peer_token_a: assert property (t2i_frame |-> peer_tok_q)
    else $error("peer framed without token");
  dev_token_a: assert property (i2t_frame |-> !peer_tok_q)
    else $error("initiator framed without token");
  single_frame_a: assert property (i2t_frame |=> !i2t_frame)
    else $error("second frame before ack");
  trig_after_ack_a: assert property (i2t_frame |-> acked_s ##0 handback_s)
    else $error("token returned out of order");
  dev_reply_a: assert property (t2i_trig |-> ##[1:4] (i2t_frame || i2t_trig))
    else $error("initiator kept token idle");
  peer_reply_a: assert property (i2t_trig |-> ##[1:4] (t2i_frame || t2i_trig))
    else $error("peer kept token idle");
  one_token_a: assert property (!(i2t_trig && t2i_trig))
    else $error("both ends passing token");
endmodule

// file: tb/serial_ipc_write_initiator_tb.sv
// Self-checking bench for both link ends
`timescale 1ns/1ps
module serial_ipc_write_initiator_tb;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic [5:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = '0, rdata, tx_data = '0, rx_data;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, irq, tx_busy, tx_done, tx_timeout, rx_valid;
  logic [1:0] bresp, rresp, rx_chan, tx_chan = '0;
  logic tx_req = 1'b0, tx_stream = 1'b0, rx_stream;
  int err_count = 0, tests_run = 0, rx_seen = 0;

  always #25 mclk = ~mclk;

  // Frame strobes seen at the peer
  always @(posedge mclk)
  begin
    if (rx_valid === 1'b1)
      rx_seen <= rx_seen + 1;
  end

  // ----------------------------------------
  // Design ends and checker
  // ----------------------------------------
  ipc_link_if link();
  ipc_dev_end u_ipc_dev_end (.mclk(mclk), .rst_b(rst_b), .link(link), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .irq(irq));
  ipc_peer_end u_ipc_peer_end (.mclk(mclk), .rst_b(rst_b), .link(link), .tx_req(tx_req),
    .tx_chan(tx_chan), .tx_stream(tx_stream), .tx_data(tx_data), .tx_busy(tx_busy),
    .tx_done(tx_done), .tx_timeout(tx_timeout), .rx_valid(rx_valid), .rx_chan(rx_chan),
    .rx_stream(rx_stream), .rx_data(rx_data));
  ipc_link_chk u_ipc_link_chk (.mclk(mclk), .rst_b(rst_b), .i2t_frame(link.i2t_frame),
    .i2t_chan(link.i2t_chan), .i2t_trig(link.i2t_trig), .i2t_ack(link.i2t_ack),
    .i2t_ack_chan(link.i2t_ack_chan), .t2i_frame(link.t2i_frame), .t2i_chan(link.t2i_chan),
    .t2i_trig(link.t2i_trig), .t2i_ack(link.t2i_ack), .t2i_ack_chan(link.t2i_ack_chan));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    tests_run++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic axi_wr(input logic [5:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (awready === 1'b1)
        awvalid <= 1'b0;
      if (wready === 1'b1)
        wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (arready === 1'b1)
        arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic launch(input int ch, input logic strm, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(ipc_pkg::OFF_DATA0 + 6'(4 * ch), d, r);
    axi_wr(ipc_pkg::OFF_CMD0 + 6'(4 * ch),
      32'h1 << (strm ? ipc_pkg::CMD_STREAM_BIT : ipc_pkg::CMD_WRITE_BIT), r);
  endtask

  task automatic wait_ack(input int ch, output logic [31:0] s);
    logic [1:0] r;
    for (int n = 0; n < 30; n++)
    begin
      axi_rd(ipc_pkg::OFF_STAT, s, r);
      if (s[ch] === 1'b1)
        break;
    end
  endtask

  task automatic peer_tx(input logic [1:0] c, input logic strm, input logic [31:0] d);
    @(posedge mclk);
    tx_chan <= c;
    tx_stream <= strm;
    tx_data <= d;
    tx_req <= 1'b1;
    for (int n = 0; n < 60 && tx_busy !== 1'b1; n++)
      @(posedge mclk);
    tx_req <= 1'b0;
    for (int n = 0; n < 300 && tx_done !== 1'b1; n++)
    begin
      @(posedge mclk);
      check(tx_timeout, 1'b0, "peer frame timed out");
    end
    check(tx_done, 1'b1, "peer frame not acked");
    check(tx_busy, 1'b0, "peer still busy");
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial
  begin
    repeat (30000) @(posedge mclk);
    err_count++;
    summarize();
  end

  initial
  begin
    int ch, pch;
    logic strm, msk;
    logic [31:0] d, pd, v;
    logic [1:0] r;
    void'($urandom(32174));
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    axi_rd(ipc_pkg::OFF_IRQ_MASK, v, r);
    check(v, 32'(ipc_pkg::IRQ_MASK_RST), "mask reset");
    axi_rd(ipc_pkg::OFF_ERR, v, r);
    check(v[3:0], 4'h0, "error reset");
    axi_rd(ipc_pkg::OFF_DATA0, v, r);
    check(v, ipc_pkg::DATA_RST, "data reset");
    axi_wr(ipc_pkg::OFF_DATA0, 32'hFFFF_FFFF, r);
    wstrb <= 4'h1;
    axi_wr(ipc_pkg::OFF_DATA0, 32'h0000_0000, r);
    wstrb <= 4'hF;
    axi_rd(ipc_pkg::OFF_DATA0, v, r);
    check(v, 32'hFFFF_FF00, "byte lane merge");
    axi_rd(6'h38, v, r);
    check(r, ipc_pkg::RESP_SLVERR, "unmapped read");
    axi_wr(6'h38, 32'hFFFF_FFFF, r);
    check(r, ipc_pkg::RESP_SLVERR, "unmapped write");
    $display("test reset done");
    for (int i = 0; i < 12; i++)
    begin
      ch = (i < 4) ? i : $urandom_range(3, 0);
      strm = (i < 4) ? i[0] : 1'($urandom_range(1, 0));
      d = (i == 0) ? 32'hFFFF_FFFF : $urandom;
      msk = (i < 2) ? i[0] : 1'($urandom_range(1, 0));
      axi_wr(ipc_pkg::OFF_IRQ_MASK, msk ? (32'h1 << ch) : 32'h0, r);
      launch(ch, strm, d);
      wait_ack(ch, v);
      check(v[ch], 1'b1, "ack bit");
      check(v[4 + ch], 1'b0, "outstanding bit");
      check(rx_seen, i + 1, "frame count");
      check(rx_data, d, "frame data");
      check({rx_chan, rx_stream}, {2'(ch), strm}, "frame kind");
      axi_rd(ipc_pkg::OFF_CMD0 + 6'(4 * ch), v, r);
      check(v[1:0], 2'h0, "pending left set");
      repeat (2) @(posedge mclk);
      check(irq, msk, "ack interrupt");
      axi_rd(ipc_pkg::OFF_IRQ_STAT, v, r);
      check(v[ch], 1'b1, "ack status");
      axi_wr(ipc_pkg::OFF_IRQ_STAT, 32'h0000_01FF, r);
      repeat (2) @(posedge mclk);
      check(irq, 1'b0, "interrupt cleared");
    end
    axi_rd(ipc_pkg::OFF_ERR, v, r);
    check(v[3:0], 4'h0, "timeout after clean writes");
    $display("test initiator writes done");
    for (int i = 0; i < 8; i++)
    begin
      ch = $urandom_range(3, 0);
      pch = $urandom_range(3, 0);
      strm = 1'($urandom_range(1, 0));
      d = $urandom;
      pd = $urandom;
      fork
        peer_tx(2'(pch), ~strm, pd);
        launch(ch, strm, d);
      join
      wait_ack(ch, v);
      check(v[ch], 1'b1, "ack bit under traffic");
      check(rx_seen, 13 + i, "frame count under traffic");
      check(rx_data, d, "frame data under traffic");
      axi_rd(ipc_pkg::OFF_RX_DATA, v, r);
      check(v, pd, "peer data");
      axi_rd(ipc_pkg::OFF_RX_INFO, v, r);
      check({v[ipc_pkg::RXI_STREAM_BIT], v[1:0]}, {~strm, 2'(pch)}, "peer kind");
      axi_rd(ipc_pkg::OFF_IRQ_STAT, v, r);
      check(v[ipc_pkg::IRQ_RX_BIT], 1'b1, "peer frame status");
      axi_wr(ipc_pkg::OFF_IRQ_STAT, 32'h0000_01FF, r);
    end
    $display("test token exchange done");
    summarize();
  end
endmodule
